/* rtl/ihp_dev.sv */
// Port controller host side: two-wire slave, register file, interrupt pin.
// Assumes bus pins arrive synchronous to core_clk; the master clocks slowly.
//
// Contract
// - Full two-wire slave at fast-mode speed
// - Read without index starts at pointer
// - Power-up: strapped role, audio on, masked
// - Strap high or low gives bus mode
// - Bus mode: port logic idle until enable bit set; float mode always active
// - Interrupt pin open-drain, released after reset
// - Unmasking alone keeps interrupt pin released
// - Event pulls pin low, one-write releases
// - Global mask set keeps pin released
// - Masked events recorded, pin low on unmask
// - Status bits sticky, cleared by one
// - Slave address 0,1,S,0,0,0,1 plus direction
// - Bus access available within 100 ms
// - Strap: high 62h, float pins, low 42h
// - Straps sampled at enable fall or power-up
// - Soft reset reinitialises and resamples straps
`timescale 1ns/1ps
`default_nettype none
`include "ihp_params.svh"
module ihp_dev
    import ihp_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5A // Arbitrary value
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic chip_enable_low,
    input wire logic [1:0] port_role_pin,
    input wire logic [1:0] address_select_pin,
    input wire logic [7:0] irq_event,
    ihp_if.dev bus,
    output logic port_active,
    output logic [2:0] port_role,
    output logic audio_en,
    output logic i2c_mode
);

////////////////////////////////////////////////////////////////////////
// Initialisation and strap sampling

logic init;
logic init_q;
logic samp;
logic soft_q;
logic soft_pend_q;
logic i2c_mode_q;
logic addr_hi_q;
logic [6:0] my_addr;

assign init = rst | soft_q | chip_enable_low;
assign samp = init_q & ~init;
assign my_addr = addr_hi_q ? `IHP_ADDR_HI : `IHP_ADDR_LO;

always_ff @(posedge core_clk)
begin
    if (rst)
        init_q <= 1'b1;
    else
        init_q <= init;
end

always_ff @(posedge core_clk)
begin
    if (rst)
    begin
        i2c_mode_q <= 1'b0;
        addr_hi_q <= 1'b0;
    end
    else if (samp)
    begin
        i2c_mode_q <= address_select_pin != IHP_TRI_FLOAT;
        addr_hi_q <= address_select_pin == IHP_TRI_HIGH;
    end
end

function automatic logic [2:0] role_of(input logic [1:0] pin);
    begin
        case (pin)
            IHP_TRI_HIGH: role_of = `IHP_ROLE_SRC;
            IHP_TRI_LOW: role_of = `IHP_ROLE_SNK;
            default: role_of = `IHP_ROLE_DRP;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Bus edge detection

logic scl_q;
logic sda_q;
logic scl_rise;
logic scl_fall;
logic start_c;
logic stop_c;

always_ff @(posedge core_clk)
begin
    if (rst)
    begin
        scl_q <= 1'b1;
        sda_q <= 1'b1;
    end
    else
    begin
        scl_q <= bus.scl;
        sda_q <= bus.sda;
    end
end

assign scl_rise = bus.scl & ~scl_q;
assign scl_fall = ~bus.scl & scl_q;
assign start_c = i2c_mode_q & bus.scl & scl_q & sda_q & ~bus.sda;
assign stop_c = bus.scl & scl_q & ~sda_q & bus.sda;

////////////////////////////////////////////////////////////////////////
// Register file

logic [7:0] role_q;
logic [7:0] ctrl_q;
logic [7:0] ctrl1_q;
logic [7:0] mask_q;
logic [7:0] int_q;
logic [7:0] ptr_q;
logic [7:0] sh_q;
logic wr_now;
logic [7:0] int_clr;

// Unmapped and reserved locations read as zero
function automatic logic [7:0] reg_rd(input logic [7:0] a);
    begin
        case (a)
            `IHP_REG_ID: reg_rd = DEVICE_ID;
            `IHP_REG_ROLE: reg_rd = role_q;
            `IHP_REG_CTRL: reg_rd = ctrl_q;
            `IHP_REG_CTRL1: reg_rd = ctrl1_q;
            `IHP_REG_MASK: reg_rd = mask_q;
            `IHP_REG_INT: reg_rd = int_q;
            default: reg_rd = 8'h00;
        endcase
    end
endfunction

always_ff @(posedge core_clk)
begin
    if (init)
    begin
        role_q <= `IHP_ROLE_RST;
        ctrl_q <= `IHP_CTRL_RST;
        ctrl1_q <= `IHP_CTRL1_RST;
        mask_q <= `IHP_MASK_RST;
    end
    else if (samp)
        role_q <= {role_q[7:3], role_of(port_role_pin)};
    else if (wr_now)
    begin
        case (ptr_q)
            `IHP_REG_ROLE: role_q <= sh_q;
            `IHP_REG_CTRL: ctrl_q <= sh_q;
            `IHP_REG_CTRL1: ctrl1_q <= sh_q;
            `IHP_REG_MASK: mask_q <= sh_q;
            default: role_q <= role_q;
        endcase
    end
end

assign int_clr = (wr_now && ptr_q == `IHP_REG_INT) ? sh_q : 8'h00;

// A new event in the clearing cycle survives the clear
always_ff @(posedge core_clk)
begin
    if (init)
        int_q <= 8'h00;
    else
        int_q <= (int_q & ~int_clr) | irq_event;
end

// Soft reset waits for the stop so the write itself is acknowledged
always_ff @(posedge core_clk)
begin
    if (init)
    begin
        soft_pend_q <= 1'b0;
        soft_q <= 1'b0;
    end
    else
    begin
        if (wr_now && ptr_q == `IHP_REG_RESET && sh_q[`IHP_B_SOFT_RESET_BIT])
            soft_pend_q <= 1'b1;
        soft_q <= soft_pend_q & stop_c;
    end
end

////////////////////////////////////////////////////////////////////////
// Slave state machine

ihp_dstate_e st_q;
logic [3:0] bit_q;
logic idx_q;
logic rw_q;
logic nack_q;
logic sda_oe_q;
logic [7:0] rd_byte;

assign wr_now = st_q == DS_WDATA && scl_fall && bit_q == 4'h8 && !idx_q;
assign rd_byte = reg_rd(ptr_q);

always_ff @(posedge core_clk)
begin
    if (init)
    begin
        st_q <= DS_IDLE;
        bit_q <= 4'h0;
        sh_q <= 8'h00;
        ptr_q <= 8'h00;
        idx_q <= 1'b0;
        rw_q <= 1'b0;
        nack_q <= 1'b0;
        sda_oe_q <= 1'b0;
    end
    else if (start_c)
    begin
        st_q <= DS_ADDR;
        bit_q <= 4'h0;
        sda_oe_q <= 1'b0;
    end
    else if (stop_c)
    begin
        st_q <= DS_IDLE;
        sda_oe_q <= 1'b0;
    end
    else
    begin
        case (st_q)
            DS_ADDR, DS_WDATA:
            begin
                if (scl_rise)
                begin
                    sh_q <= {sh_q[6:0], bus.sda};
                    bit_q <= bit_q + 4'h1;
                end
                else if (scl_fall && bit_q == 4'h8)
                begin
                    if (st_q == DS_ADDR)
                    begin
                        if (sh_q[7:1] == my_addr)
                        begin
                            sda_oe_q <= 1'b1;
                            rw_q <= sh_q[0];
                            idx_q <= 1'b1;
                            st_q <= DS_AACK;
                        end
                        else
                            st_q <= DS_IDLE;
                    end
                    else
                    begin
                        sda_oe_q <= 1'b1;
                        st_q <= DS_WACK;
                        idx_q <= 1'b0;
                        ptr_q <= idx_q ? sh_q : ptr_q + 8'h01;
                    end
                end
            end
            DS_AACK, DS_WACK:
            begin
                if (scl_fall)
                begin
                    bit_q <= 4'h0;
                    if (st_q == DS_AACK && rw_q)
                    begin
                        sh_q <= rd_byte;
                        sda_oe_q <= ~rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= DS_RDATA;
                    end
                    else
                    begin
                        sda_oe_q <= 1'b0;
                        st_q <= DS_WDATA;
                    end
                end
            end
            DS_RDATA:
            begin
                if (scl_rise)
                    bit_q <= bit_q + 4'h1;
                else if (scl_fall && bit_q == 4'h8)
                begin
                    sda_oe_q <= 1'b0;
                    st_q <= DS_RACK;
                end
                else if (scl_fall)
                begin
                    sh_q <= {sh_q[6:0], 1'b0};
                    sda_oe_q <= ~sh_q[6];
                end
            end
            DS_RACK:
            begin
                if (scl_rise)
                    nack_q <= bus.sda;
                else if (scl_fall && nack_q)
                    st_q <= DS_IDLE;
                else if (scl_fall)
                begin
                    bit_q <= 4'h0;
                    sh_q <= rd_byte;
                    sda_oe_q <= ~rd_byte[7];
                    ptr_q <= ptr_q + 8'h01;
                    st_q <= DS_RDATA;
                end
            end
            default: st_q <= DS_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Interrupt pin and user-side outputs

logic irq_oe_q;
logic port_active_q;

always_ff @(posedge core_clk)
begin
    if (init)
        irq_oe_q <= 1'b0;
    else
        irq_oe_q <= i2c_mode_q && !ctrl_q[`IHP_B_INT_MASK] && |(int_q & ~mask_q);
end

always_ff @(posedge core_clk)
begin
    if (init)
        port_active_q <= 1'b0;
    else
        port_active_q <= !i2c_mode_q || ctrl1_q[`IHP_B_ENABLE];
end

assign bus.sda_oe_dev = sda_oe_q;
assign bus.irq_oe_dev = irq_oe_q;
assign port_active = port_active_q;
assign port_role = role_q[2:0];
assign audio_en = role_q[`IHP_B_AUDIO];
assign i2c_mode = i2c_mode_q;

endmodule
`default_nettype wire

/* rtl/ihp_host.sv */
// Processor end: two-wire master driven from a small register port.
// Assumes one master on the bus and a slave that never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
`include "ihp_params.svh"
module ihp_host
    import ihp_pkg::*;
#(
    parameter int BOOT_WAIT_CYC = `IHP_T_EN_CYC
)
(
    input wire logic core_clk,
    input wire logic rst,
    ihp_if.host bus,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data
);

////////////////////////////////////////////////////////////////////////
// Start-up wait before the first bus access

logic [21:0] boot_q;
logic boot_done_q;

always_ff @(posedge core_clk)
begin
    if (rst)
    begin
        boot_q <= 22'h000000;
        boot_done_q <= 1'b0;
    end
    else if (!boot_done_q)
    begin
        boot_q <= boot_q + 22'h000001;
        if (boot_q == 22'(BOOT_WAIT_CYC - 1))
            boot_done_q <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// Command and data registers

ihp_hstate_e st_q;
logic p_start_q;
logic p_byte_q;
logic p_read_q;
logic p_nack_q;
logic p_stop_q;
logic [7:0] tx_q;
logic [7:0] rx_q;
logic [7:0] sh_q;
logic nack_q;
logic busy;
logic take;
logic [1:0] ph_q;
logic [3:0] bit_q;
logic [4:0] qc_q;
logic tick;
logic scl_oe_q;
logic sda_oe_q;
logic [7:0] rd_q;

assign busy = st_q != HS_IDLE || p_start_q || p_byte_q || p_stop_q;
// Commands while busy or before start-up are dropped
assign take = wr_stb && reg_addr == `IHP_H_CTRL && !busy && boot_done_q;
assign tick = qc_q == 5'(`IHP_QTR_CYC - 1);

always_ff @(posedge core_clk)
begin
    if (rst)
        tx_q <= 8'h00;
    else if (wr_stb && reg_addr == `IHP_H_TX)
        tx_q <= wr_data;
end

always_ff @(posedge core_clk)
begin
    if (rst)
        rd_q <= 8'h00;
    else if (rd_stb && reg_addr == `IHP_H_RX)
        rd_q <= rx_q;
    else if (rd_stb && reg_addr == `IHP_H_STAT)
        rd_q <= {4'h0, boot_done_q, ~bus.irq_n, nack_q, busy};
    else
        rd_q <= 8'h00;
end

always_ff @(posedge core_clk)
begin
    if (rst || st_q == HS_IDLE || tick)
        qc_q <= 5'h00;
    else
        qc_q <= qc_q + 5'h01;
end

////////////////////////////////////////////////////////////////////////
// Sequencer: start, then one byte, then stop, each if ordered

always_ff @(posedge core_clk)
begin
    if (rst)
    begin
        st_q <= HS_IDLE;
        {p_start_q, p_byte_q, p_read_q, p_nack_q, p_stop_q} <= 5'h00;
        sh_q <= 8'h00;
        rx_q <= 8'h00;
        nack_q <= 1'b0;
        ph_q <= 2'h0;
        bit_q <= 4'h0;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
    end
    else if (take)
    begin
        p_start_q <= wr_data[`IHP_HC_START];
        p_byte_q <= wr_data[`IHP_HC_BYTE];
        p_read_q <= wr_data[`IHP_HC_READ];
        p_nack_q <= wr_data[`IHP_HC_NACK];
        p_stop_q <= wr_data[`IHP_HC_STOP];
        sh_q <= tx_q;
    end
    else
    begin
        case (st_q)
            HS_IDLE:
            begin
                ph_q <= 2'h0;
                bit_q <= 4'h0;
                if (p_start_q)
                    st_q <= HS_START;
                else if (p_byte_q)
                    st_q <= HS_BIT;
                else if (p_stop_q)
                    st_q <= HS_STOP;
            end
            HS_START, HS_STOP:
            begin
                if (tick)
                begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: sda_oe_q <= st_q == HS_STOP;
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2: sda_oe_q <= st_q == HS_START;
                        default:
                        begin
                            scl_oe_q <= st_q == HS_START;
                            p_start_q <= 1'b0;
                            if (st_q == HS_STOP)
                                p_stop_q <= 1'b0;
                            st_q <= HS_IDLE;
                        end
                    endcase
                end
            end
            HS_BIT:
            begin
                if (tick)
                begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0:
                        begin
                            if (bit_q == 4'h8)
                                sda_oe_q <= p_read_q && !p_nack_q;
                            else
                                sda_oe_q <= !p_read_q && !sh_q[7];
                        end
                        2'h1: scl_oe_q <= 1'b0;
                        2'h2:
                        begin
                            if (bit_q == 4'h8)
                                nack_q <= !p_read_q && bus.sda;
                            else
                                sh_q <= {sh_q[6:0], bus.sda};
                        end
                        default:
                        begin
                            scl_oe_q <= 1'b1;
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h8)
                            begin
                                rx_q <= sh_q;
                                p_byte_q <= 1'b0;
                                sda_oe_q <= 1'b0;
                                st_q <= HS_IDLE;
                            end
                        end
                    endcase
                end
            end
            default: st_q <= HS_IDLE;
        endcase
    end
end

assign bus.scl_oe_host = scl_oe_q;
assign bus.sda_oe_host = sda_oe_q;
assign rd_data = rd_q;

endmodule
`default_nettype wire

/* rtl/ihp_if.sv */
// Two-wire bus and interrupt line between processor and port controller.
// Open-drain levels are resolved here from the output enables.
`timescale 1ns/1ps
`default_nettype none
interface ihp_if;
    logic scl_oe_host;
    logic sda_oe_host;
    logic sda_oe_dev;
    logic irq_oe_dev;
    logic scl;
    logic sda;
    logic irq_n;
    assign scl = ~scl_oe_host;
    assign sda = ~(sda_oe_host | sda_oe_dev);
    assign irq_n = ~irq_oe_dev;
    modport dev (input scl, input sda, output sda_oe_dev, output irq_oe_dev);
    modport host (input scl, input sda, input irq_n, output scl_oe_host, output sda_oe_host);
endinterface
`default_nettype wire

/* rtl/ihp_params.svh */
// Constants shared by both ends of the host port link.
// Assumes a 40 MHz core clock on both ends.
`ifndef IHP_PARAMS_SVH
`define IHP_PARAMS_SVH
`define IHP_CLK_NS 25
`define IHP_T_EN_MS 100
`define IHP_T_EN_CYC (`IHP_T_EN_MS * 1000000 / `IHP_CLK_NS)
`define IHP_SCL_NS 2500
`define IHP_QTR_CYC ((`IHP_SCL_NS + 4 * `IHP_CLK_NS - 1) / (4 * `IHP_CLK_NS))
`define IHP_ADDR_HI 7'h31
`define IHP_ADDR_LO 7'h21
`define IHP_REG_ID 8'h01
`define IHP_REG_ROLE 8'h03
`define IHP_REG_CTRL 8'h04
`define IHP_REG_CTRL1 8'h05
`define IHP_REG_RESET 8'h0A
`define IHP_REG_MASK 8'h0E
`define IHP_REG_INT 8'h14
`define IHP_ROLE_RST 8'h48
`define IHP_CTRL_RST 8'h43
`define IHP_CTRL1_RST 8'h23
`define IHP_MASK_RST 8'hFF
`define IHP_B_INT_MASK 0
`define IHP_B_ENABLE 3
`define IHP_B_SOFT_RESET_BIT 0
`define IHP_B_AUDIO 3
`define IHP_ROLE_SRC 3'h1
`define IHP_ROLE_SNK 3'h2
`define IHP_ROLE_DRP 3'h4
`define IHP_H_CTRL 2'h0
`define IHP_H_TX 2'h1
`define IHP_H_RX 2'h2
`define IHP_H_STAT 2'h3
`define IHP_HC_START 0
`define IHP_HC_BYTE 1
`define IHP_HC_READ 2
`define IHP_HC_NACK 3
`define IHP_HC_STOP 4
`endif

/* rtl/ihp_pkg.sv */
// Types shared by both ends of the host port link.
// Assumes the constants header is included by each module file.
`default_nettype none
package ihp_pkg;
    // Three-level strap pin as seen by the core
    typedef enum logic [1:0] {IHP_TRI_LOW = 2'h0, IHP_TRI_FLOAT = 2'h1, IHP_TRI_HIGH = 2'h2} ihp_tri_e;
    typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_AACK, DS_WDATA, DS_WACK, DS_RDATA, DS_RACK} ihp_dstate_e;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} ihp_hstate_e;
endpackage
`default_nettype wire

/* tb/i2c_host_port_interrupt_ctrl_test.sv */
// Self-checking bench: processor end and port controller joined over the link.
// Assumes the shared constants header and a 40 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "ihp_params.svh"
module i2c_host_port_interrupt_ctrl_test;
    localparam logic [7:0] ID_EXP = 8'h5A; // Arbitrary value
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic chip_enable_low = 1'b0;
    logic [1:0] port_role_pin = 2'h0;
    logic [1:0] address_select_pin = 2'h0;
    logic [7:0] irq_event = 8'h00;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rd_data;
    logic port_active;
    logic [2:0] port_role;
    logic audio_en;
    logic i2c_mode;
    logic [7:0] st;
    logic [7:0] got;
    logic [7:0] dev_addr = 8'h42;
    int failures = 0;
    int comparisons = 0;

    ihp_if bus_if();
    ihp_dev #(.DEVICE_ID(ID_EXP)) ihp_dev_inst (.core_clk(core_clk), .rst(rst), .chip_enable_low(chip_enable_low),
        .port_role_pin(port_role_pin), .address_select_pin(address_select_pin), .irq_event(irq_event),
        .bus(bus_if), .port_active(port_active), .port_role(port_role), .audio_en(audio_en), .i2c_mode(i2c_mode));
    ihp_host #(.BOOT_WAIT_CYC(10)) ihp_host_inst (.core_clk(core_clk), .rst(rst), .bus(bus_if), .reg_addr(reg_addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));
    ihp_monitor ihp_monitor_inst (.core_clk(core_clk), .rst(rst), .scl_oe_host(bus_if.scl_oe_host),
        .sda_oe_host(bus_if.sda_oe_host), .sda_oe_dev(bus_if.sda_oe_dev), .irq_oe_dev(bus_if.irq_oe_dev),
        .scl(bus_if.scl), .sda(bus_if.sda), .irq_n(bus_if.irq_n));

    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got_v, input logic [7:0] exp_v);
        comparisons++;
        if (got_v !== exp_v)
        begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask

    // One host command; TX goes first because it is copied when CTRL is taken
    task automatic op(input logic [7:0] ctrl, input logic [7:0] tx);
        int n;
        wr(`IHP_H_TX, tx);
        wr(`IHP_H_CTRL, ctrl);
        n = 0;
        st = 8'h01;
        while (st[0] !== 1'b0)
        begin
            rd(`IHP_H_STAT, st);
            n++;
            if (n > 2000)
            begin
                failures++;
                $display("BAD %0t host stuck busy", $time);
                test_done();
            end
        end
    endtask

    task automatic dev_wr(input logic [7:0] idx, input logic [7:0] d);
        op(8'h03, dev_addr);
        cmp(st & 8'h02, 8'h00);
        op(8'h02, idx);
        op(8'h12, d);
        cmp(st & 8'h02, 8'h00);
    endtask

    task automatic dev_rd_cur(output logic [7:0] d);
        op(8'h03, dev_addr | 8'h01);
        cmp(st & 8'h02, 8'h00);
        op(8'h1E, 8'h00);
        rd(`IHP_H_RX, d);
    endtask

    task automatic dev_rd(input logic [7:0] idx, output logic [7:0] d);
        op(8'h03, dev_addr);
        op(8'h02, idx);
        dev_rd_cur(d);
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(posedge core_clk);
        irq_event <= ev;
        @(posedge core_clk);
        irq_event <= 8'h00;
        repeat (4) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power();
        cmp({5'h00, port_role}, 8'h02);
        cmp({6'h00, audio_en, port_active}, 8'h02);
        cmp({7'h00, bus_if.irq_n}, 8'h01);
        op(8'h03, dev_addr);
        op(8'h02, `IHP_REG_ROLE);
        op(8'h03, dev_addr | 8'h01);
        op(8'h06, 8'h00);
        rd(`IHP_H_RX, got);
        cmp(got, 8'h4A);
        op(8'h06, 8'h00);
        rd(`IHP_H_RX, got);
        cmp(got, 8'h43);
        op(8'h1E, 8'h00);
        rd(`IHP_H_RX, got);
        cmp(got, 8'h23);
        dev_rd(`IHP_REG_ID, got);
        cmp(got, ID_EXP);
    endtask

    task automatic t_addr();
        op(8'h13, 8'h62);
        cmp(st & 8'h02, 8'h02);
        op(8'h03, dev_addr);
        op(8'h12, `IHP_REG_MASK);
        dev_rd_cur(got);
        cmp(got, 8'hFF);
        dev_rd_cur(got);
        cmp(got, 8'h00);
    endtask

    task automatic t_irq();
        dev_wr(`IHP_REG_MASK, 8'h00);
        dev_wr(`IHP_REG_CTRL, 8'h42);
        cmp({7'h00, bus_if.irq_n}, 8'h01);
        pulse(8'h01);
        cmp({7'h00, bus_if.irq_n}, 8'h00);
        dev_wr(`IHP_REG_INT, 8'h00);
        dev_rd(`IHP_REG_INT, got);
        cmp(got, 8'h01);
        cmp(st & 8'h04, 8'h04);
        cmp({7'h00, bus_if.irq_n}, 8'h00);
        dev_wr(`IHP_REG_INT, 8'h01);
        cmp({7'h00, bus_if.irq_n}, 8'h01);
        dev_wr(`IHP_REG_CTRL, 8'h43);
        pulse(8'h02);
        cmp({7'h00, bus_if.irq_n}, 8'h01);
        dev_rd(`IHP_REG_INT, got);
        cmp(got, 8'h02);
        dev_wr(`IHP_REG_CTRL, 8'h42);
        cmp({7'h00, bus_if.irq_n}, 8'h00);
        dev_wr(`IHP_REG_INT, 8'h02);
        cmp({7'h00, bus_if.irq_n}, 8'h01);
    endtask

    task automatic t_enable();
        cmp({7'h00, port_active}, 8'h00);
        dev_wr(`IHP_REG_CTRL1, 8'h2B);
        cmp({7'h00, port_active}, 8'h01);
    endtask

    // Straps move before the soft reset, so only a resample explains the new answers
    task automatic t_soft();
        @(posedge core_clk);
        address_select_pin <= 2'h2;
        port_role_pin <= 2'h2;
        dev_wr(`IHP_REG_RESET, 8'h01);
        repeat (8) @(posedge core_clk);
        op(8'h13, 8'h42);
        cmp(st & 8'h02, 8'h02);
        dev_addr = 8'h62;
        dev_rd(`IHP_REG_ROLE, got);
        cmp(got, 8'h49);
        cmp({7'h00, port_active}, 8'h00);
    endtask

    task automatic t_enable_pin();
        @(posedge core_clk);
        chip_enable_low <= 1'b1;
        address_select_pin <= 2'h1;
        repeat (4) @(posedge core_clk);
        chip_enable_low <= 1'b0;
        repeat (4) @(posedge core_clk);
        cmp({6'h00, i2c_mode, port_active}, 8'h01);
        op(8'h13, 8'h62);
        cmp(st & 8'h02, 8'h02);
        op(8'h13, 8'h42);
        cmp(st & 8'h02, 8'h02);
        @(posedge core_clk);
        chip_enable_low <= 1'b1;
        address_select_pin <= 2'h0;
        port_role_pin <= 2'h1;
        repeat (4) @(posedge core_clk);
        chip_enable_low <= 1'b0;
        dev_addr = 8'h42;
        dev_rd(`IHP_REG_ROLE, got);
        cmp(got, 8'h4C);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        st = 8'h00;
        repeat (50)
        begin
            if (st[3] !== 1'b1)
                rd(`IHP_H_STAT, st);
        end
        cmp(st & 8'h08, 8'h08);
        t_power();
        t_addr();
        t_irq();
        t_enable();
        t_soft();
        t_enable_pin();
        test_done();
    end
endmodule
`default_nettype wire

/* tb/ihp_monitor.sv */
// Concurrent checks on the two-wire link and the interrupt line.
// Assumes both ends share core_clk and the link signals arrive as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module ihp_monitor
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_oe_host,
    input wire logic sda_oe_host,
    input wire logic sda_oe_dev,
    input wire logic irq_oe_dev,
    input wire logic scl,
    input wire logic sda,
    input wire logic irq_n
);
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic scl_q;
    logic [15:0] high_cnt_q;
    logic [15:0] period_cnt_q;
    logic scl_rise;
    logic scl_fall;
    assign scl_rise = scl & ~scl_q;
    assign scl_fall = ~scl & scl_q;

    always_ff @(posedge core_clk)
    begin
        scl_q <= rst | scl;
    end

    // Saturating so a long idle bus never wraps into a false short phase
    always_ff @(posedge core_clk)
    begin
        if (rst)
            high_cnt_q <= 16'hFFFF;
        else if (!scl)
            high_cnt_q <= 16'h0000;
        else if (high_cnt_q != 16'hFFFF)
            high_cnt_q <= high_cnt_q + 16'h0001;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            period_cnt_q <= 16'hFFFF;
        else if (scl_rise)
            period_cnt_q <= 16'h0001;
        else if (period_cnt_q != 16'hFFFF)
            period_cnt_q <= period_cnt_q + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_dev_low_at_rise;
        sda_oe_dev && scl_rise;
    endsequence
    sequence s_dev_held;
        sda_oe_dev [*8];
    endsequence

    property p_irq_reset;
        disable iff (1'b0) rst |=> !irq_oe_dev;
    endproperty
    property p_sda_reset;
        disable iff (1'b0) rst |=> !sda_oe_dev;
    endproperty
    property p_dev_edge;
        $changed(sda_oe_dev) |-> $past(scl_oe_host) && !$past(scl_oe_host, 2);
    endproperty
    property p_dev_stable_high;
        scl && $past(scl) |-> $stable(sda_oe_dev);
    endproperty
    property p_dev_hold;
        s_dev_low_at_rise |-> s_dev_held;
    endproperty
    // A clear or a mask write lands in the cycle the acknowledge goes out
    property p_irq_clear;
        $fell(irq_oe_dev) |-> sda_oe_dev && $past(sda_oe_dev) && !$past(sda_oe_dev, 2);
    endproperty
    property p_scl_high;
        scl_fall |-> high_cnt_q >= 16'h0018;
    endproperty
    property p_scl_period;
        scl_rise |-> period_cnt_q >= 16'h0064;
    endproperty

    a_irq_reset: assert property (p_irq_reset) else $error("interrupt line driven after reset");
    a_sda_reset: assert property (p_sda_reset) else $error("data line driven after reset");
    a_dev_edge: assert property (p_dev_edge) else $error("device data change off its slot");
    a_dev_stable_high: assert property (p_dev_stable_high) else $error("device data moved with clock high");
    a_dev_hold: assert property (p_dev_hold) else $error("device low bit not held");
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt released without a write");
    a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
    a_scl_period: assert property (p_scl_period) else $error("clock faster than 400 kHz");
endmodule
`default_nettype wire
